//--- rtl/fsc_params.svh
// fsc_params.svh: offsets, field positions, reset values and widths of the sweep control block.
// assumes: included by bare name from the package and the design modules.
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

`define FSC_ADDR_W          5
`define FSC_DATA_W          30
`define FSC_ACC_W           48
`define FSC_DLY_W           21

`define FSC_OFS_TRIG_DELAY  5'h05
`define FSC_OFS_DN_CNT_HI   5'h0c
`define FSC_OFS_DN_CNT_LO   5'h0d
`define FSC_OFS_SWEEP_CTRL  5'h0e
`define FSC_OFS_DN_DWELL_HI 5'h0f
`define FSC_OFS_UP_DWELL_HI 5'h10
`define FSC_OFS_UP_DWELL_LO 5'h11
`define FSC_OFS_UP_SIZE_HI  5'h12
`define FSC_OFS_UP_SIZE_LO  5'h13
`define FSC_OFS_UP_CNT_HI   5'h14
`define FSC_OFS_UP_CNT_LO   5'h15
`define FSC_OFS_DN_DWELL_LO 5'h16
`define FSC_OFS_SEED_HI     5'h17
`define FSC_OFS_SEED_LO     5'h18
`define FSC_OFS_DN_SIZE_HI  5'h19
`define FSC_OFS_DN_SIZE_LO  5'h1a
`define FSC_OFS_STATUS      5'h1b

`define FSC_BIT_DIR         26
`define FSC_BIT_ONE_WAY     25
`define FSC_BIT_SYM         22
`define FSC_BIT_TRIG_SRC    13
`define FSC_BIT_SW_TRIG     12
`define FSC_BIT_SWEEP_EN    11
`define FSC_BIT_AUTOSEED    8
`define FSC_BIT_DLY_EN      7

`define FSC_RST_WORD        30'h0000000
`define FSC_RST_CTRL        30'h0000000
`define FSC_LO_W            18

`endif

//--- rtl/fsc_pkg.sv
// fsc_pkg: types of the sweep control block.
// assumes: fsc_params.svh sits on the include path.
`include "fsc_params.svh"
package fsc_pkg;
    typedef enum logic [2:0] {S_IDLE, S_WAIT_TRIG, S_DELAY, S_RAMP, S_DWELL, S_DONE} fsc_state_e;

    typedef struct packed {
        logic [`FSC_ACC_W-1:0] size;
        logic [`FSC_ACC_W-1:0] count;
        logic [`FSC_ACC_W-1:0] dwell;
    } fsc_ramp_s;

    typedef struct packed {
        logic                  wr;
        logic [`FSC_ADDR_W-1:0] addr;
        logic [`FSC_DATA_W-1:0] data;
    } fsc_wr_s;
endpackage : fsc_pkg

//--- rtl/fsc_regfile.sv
// fsc_regfile: the 32 word register memory, written by the serial port side, read data registered.
// assumes: one write per cycle; read data valid the cycle after the address.
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_regfile
    import fsc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // write side
    input  wire fsc_wr_s                wr,
    // read side
    input  wire logic [`FSC_ADDR_W-1:0] rd_addr,
    output logic      [`FSC_DATA_W-1:0] rd_data
);
    logic [`FSC_DATA_W-1:0] mem [0:(1<<`FSC_ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (wr.wr) begin
            mem[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= `FSC_RST_WORD;
        end else if (wr.wr && wr.addr == rd_addr) begin
            rd_data <= wr.data;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : fsc_regfile

//--- rtl/fsc_sweep.sv
// fsc_sweep: sweep control of the fractional modulator; ramp parameters, triggering, trigger delay
// and the ramp engine that steps the fractional accumulator.
// assumes: REF_CLK is the divided reference; register writes arrive as parsed words on REG_*.
//
// How it works
// - direction bit picks first ramp up or down
// - shape bit one means symmetric, zero asymmetric
// - symmetric uses up parameters both ways
// - up step size from high, low registers
// - up dwell from high, low registers
// - up step count high bits from register
// - down parameters used only when asymmetric
// - down step count from high, low registers
// - trigger source bit selects serial or pin
// - writing software trigger bit fires one trigger when the written source bit selects serial
// - delay enable bit delays each trigger
// - delay lasts programmed count of reference periods
// - delay of one fires on next edge
// - sweeping only while sweep enable set
// - one-way or two-way by sweep-count bit
// - autoseed reloads seed at every ramp start
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_sweep
    import fsc_pkg::*;
(
    // clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_N,
    // register write port from the serial side
    input  wire logic                   REG_WR,
    input  wire logic [`FSC_ADDR_W-1:0] REG_ADDR,
    input  wire logic [`FSC_DATA_W-1:0] REG_WDATA,
    // register read port
    input  wire logic [`FSC_ADDR_W-1:0] REG_RADDR,
    output logic      [`FSC_DATA_W-1:0] REG_RDATA,
    // external trigger pin, already an input
    input  wire logic                   EXTERNAL_TRIGGER_PIN,
    // start value of the fractional part
    input  wire logic [`FSC_ACC_W-1:0]  FRAC_START,
    // to the delta sigma modulator
    output logic      [`FSC_ACC_W-1:0]  FRAC_VALUE,
    output logic                        SEED_LOAD,
    output logic      [`FSC_ACC_W-1:0]  SEED_VALUE,
    output logic                        RAMP_UP,
    output logic                        SWEEP_BUSY
);
    fsc_wr_s                wr;
    logic [`FSC_DATA_W-1:0] ctrl;
    logic [`FSC_DLY_W-1:0]  delay_count;
    logic [`FSC_DATA_W-1:0] up_dwell_hi;
    logic [`FSC_LO_W-1:0]   up_dwell_lo;
    logic [`FSC_DATA_W-1:0] up_size_hi;
    logic [`FSC_LO_W-1:0]   up_size_lo;
    logic [`FSC_DATA_W-1:0] up_cnt_hi;
    logic [`FSC_LO_W-1:0]   up_cnt_lo;
    logic [`FSC_DATA_W-1:0] dn_dwell_hi;
    logic [`FSC_LO_W-1:0]   dn_dwell_lo;
    logic [`FSC_DATA_W-1:0] dn_size_hi;
    logic [`FSC_LO_W-1:0]   dn_size_lo;
    logic [`FSC_DATA_W-1:0] dn_cnt_hi;
    logic [`FSC_LO_W-1:0]   dn_cnt_lo;
    logic [`FSC_DATA_W-1:0] seed_hi;
    logic [`FSC_LO_W-1:0]   seed_lo;
    logic [`FSC_DATA_W-1:0] mem_rdata;
    logic [`FSC_ADDR_W-1:0] raddr_q;

    fsc_state_e             state;
    logic [`FSC_ACC_W-1:0]  step_left;
    logic [`FSC_ACC_W-1:0]  dwell_left;
    logic [`FSC_DLY_W-1:0]  delay_left;
    logic                   going_up;
    logic                   second_leg;
    logic                   sw_trig;
    logic                   trig_pin_q;
    logic                   trigger;
    fsc_ramp_s              ramp_up_p;
    fsc_ramp_s              ramp_dn_p;
    fsc_ramp_s              ramp_cur;

    function automatic logic [`FSC_ACC_W-1:0] join48(input logic [`FSC_DATA_W-1:0] hi,
                                                      input logic [`FSC_LO_W-1:0]   lo);
        join48 = {hi, lo};
    endfunction : join48

    function automatic logic hit(input logic [`FSC_ADDR_W-1:0] ofs);
        hit = REG_WR && (REG_ADDR == ofs);
    endfunction : hit

    assign wr.wr   = REG_WR;
    assign wr.addr = REG_ADDR;
    assign wr.data = REG_WDATA;

    // memory keeps a readable copy of every written word
    fsc_regfile u_regfile (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .wr      (wr),
        .rd_addr (REG_RADDR),
        .rd_data (mem_rdata)
    );

    // control word; software trigger bit is self clearing
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctrl <= `FSC_RST_CTRL;
        end else if (hit(`FSC_OFS_SWEEP_CTRL)) begin
            ctrl <= REG_WDATA;
            ctrl[`FSC_BIT_SW_TRIG] <= 1'b0;
        end
    end

    // trigger delay register
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            delay_count <= '0;
        end else if (hit(`FSC_OFS_TRIG_DELAY)) begin
            delay_count <= REG_WDATA[`FSC_DLY_W-1:0];
        end
    end

    // up ramp parameters
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            up_dwell_hi <= '0;
            up_dwell_lo <= '0;
            up_size_hi  <= '0;
            up_size_lo  <= '0;
            up_cnt_hi   <= '0;
            up_cnt_lo   <= '0;
        end else begin
            if (hit(`FSC_OFS_UP_DWELL_HI)) up_dwell_hi <= REG_WDATA;
            if (hit(`FSC_OFS_UP_DWELL_LO)) up_dwell_lo <= REG_WDATA[`FSC_LO_W-1:0];
            if (hit(`FSC_OFS_UP_SIZE_HI))  up_size_hi  <= REG_WDATA;
            if (hit(`FSC_OFS_UP_SIZE_LO))  up_size_lo  <= REG_WDATA[`FSC_LO_W-1:0];
            if (hit(`FSC_OFS_UP_CNT_HI))   up_cnt_hi   <= REG_WDATA;
            if (hit(`FSC_OFS_UP_CNT_LO))   up_cnt_lo   <= REG_WDATA[`FSC_LO_W-1:0];
        end
    end

    // down ramp parameters
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            dn_dwell_hi <= '0;
            dn_dwell_lo <= '0;
            dn_size_hi  <= '0;
            dn_size_lo  <= '0;
            dn_cnt_hi   <= '0;
            dn_cnt_lo   <= '0;
        end else begin
            if (hit(`FSC_OFS_DN_DWELL_HI)) dn_dwell_hi <= REG_WDATA;
            if (hit(`FSC_OFS_DN_DWELL_LO)) dn_dwell_lo <= REG_WDATA[`FSC_LO_W-1:0];
            if (hit(`FSC_OFS_DN_SIZE_HI))  dn_size_hi  <= REG_WDATA;
            if (hit(`FSC_OFS_DN_SIZE_LO))  dn_size_lo  <= REG_WDATA[`FSC_LO_W-1:0];
            if (hit(`FSC_OFS_DN_CNT_HI))   dn_cnt_hi   <= REG_WDATA;
            if (hit(`FSC_OFS_DN_CNT_LO))   dn_cnt_lo   <= REG_WDATA[`FSC_LO_W-1:0];
        end
    end

    // seed words
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            seed_hi <= '0;
            seed_lo <= '0;
        end else begin
            if (hit(`FSC_OFS_SEED_HI)) seed_hi <= REG_WDATA;
            if (hit(`FSC_OFS_SEED_LO)) seed_lo <= REG_WDATA[`FSC_LO_W-1:0];
        end
    end

    assign ramp_up_p.size  = join48(up_size_hi, up_size_lo);
    assign ramp_up_p.count = join48(up_cnt_hi, up_cnt_lo);
    assign ramp_up_p.dwell = join48(up_dwell_hi, up_dwell_lo);
    assign ramp_dn_p.size  = join48(dn_size_hi, dn_size_lo);
    assign ramp_dn_p.count = join48(dn_cnt_hi, dn_cnt_lo);
    assign ramp_dn_p.dwell = join48(dn_dwell_hi, dn_dwell_lo);

    // symmetric shape ignores the down set entirely
    assign ramp_cur = (going_up || ctrl[`FSC_BIT_SYM]) ? ramp_up_p : ramp_dn_p;

    // software trigger pulse and pin rising edge
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sw_trig    <= 1'b0;
            trig_pin_q <= 1'b0;
        end else begin
            sw_trig    <= hit(`FSC_OFS_SWEEP_CTRL) && REG_WDATA[`FSC_BIT_SW_TRIG]
                          && !REG_WDATA[`FSC_BIT_TRIG_SRC];
            trig_pin_q <= EXTERNAL_TRIGGER_PIN;
        end
    end

    assign trigger = ctrl[`FSC_BIT_TRIG_SRC] ? (EXTERNAL_TRIGGER_PIN && !trig_pin_q) : sw_trig;

    // ramp engine
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state      <= S_IDLE;
            step_left  <= '0;
            dwell_left <= '0;
            delay_left <= '0;
            going_up   <= 1'b0;
            second_leg <= 1'b0;
            FRAC_VALUE <= '0;
            SEED_LOAD  <= 1'b0;
        end else begin
            SEED_LOAD <= 1'b0;
            if (!ctrl[`FSC_BIT_SWEEP_EN]) begin
                state      <= S_IDLE;
                FRAC_VALUE <= FRAC_START;
            end else begin
                case (state)
                    S_IDLE: begin
                        going_up   <= ctrl[`FSC_BIT_DIR];
                        second_leg <= 1'b0;
                        FRAC_VALUE <= FRAC_START;
                        state      <= S_WAIT_TRIG;
                    end
                    S_WAIT_TRIG, S_DONE: begin
                        if (trigger) begin
                            if (state == S_DONE) begin
                                going_up   <= ctrl[`FSC_BIT_DIR];
                                second_leg <= 1'b0;
                                FRAC_VALUE <= FRAC_START;
                            end
                            if (ctrl[`FSC_BIT_DLY_EN] && delay_count != '0) begin
                                delay_left <= delay_count - 1'b1;
                                state      <= S_DELAY;
                            end else begin
                                state <= S_RAMP;
                            end
                            step_left <= '0;
                        end
                    end
                    S_DELAY: begin
                        if (delay_left == '0) begin
                            state <= S_RAMP;
                        end else begin
                            delay_left <= delay_left - 1'b1;
                        end
                    end
                    S_RAMP: begin
                        // step_left is zero in this state only before a leg is loaded
                        if (step_left == '0) begin
                            step_left <= ramp_cur.count;
                            SEED_LOAD <= ctrl[`FSC_BIT_AUTOSEED];
                        end
                        if (step_left == 48'h1) begin
                            dwell_left <= ramp_cur.dwell;
                            state      <= S_DWELL;
                        end
                        if (step_left != '0) begin
                            step_left  <= step_left - 1'b1;
                            FRAC_VALUE <= going_up ? FRAC_VALUE + ramp_cur.size
                                                   : FRAC_VALUE - ramp_cur.size;
                        end else if (ramp_cur.count == '0) begin
                            state <= S_DONE;
                        end
                    end
                    S_DWELL: begin
                        if (dwell_left > 48'h1) begin
                            dwell_left <= dwell_left - 1'b1;
                        end else if (ctrl[`FSC_BIT_ONE_WAY] || second_leg) begin
                            state <= S_DONE;
                        end else begin
                            going_up   <= !going_up;
                            second_leg <= 1'b1;
                            step_left  <= '0;
                            state      <= S_RAMP;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    assign SEED_VALUE = join48(seed_hi, seed_lo);
    assign RAMP_UP    = going_up;
    assign SWEEP_BUSY = (state == S_DELAY) || (state == S_RAMP) || (state == S_DWELL);

    // read side: status word built from live state, control word from ctrl, other words from memory
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            raddr_q <= '0;
        end else begin
            raddr_q <= REG_RADDR;
        end
    end

    always_comb begin
        if (raddr_q == `FSC_OFS_STATUS) begin
            REG_RDATA = {25'h0, second_leg, going_up, state};
        end else if (raddr_q == `FSC_OFS_SWEEP_CTRL) begin
            REG_RDATA = ctrl;
        end else begin
            REG_RDATA = mem_rdata;
        end
    end
endmodule : fsc_sweep

//--- tb/fsc_sweep_bench.sv
// fsc_sweep_bench: self-checking bench of the sweep control block.
// assumes: fsc_sweep compiled with the package; checker bound separately.
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_sweep_bench
    import fsc_pkg::*;
();
    logic                   ref_clk    = 1'b0;
    logic                   rst_n      = 1'b0;
    logic                   reg_wr     = 1'b0;
    logic [`FSC_ADDR_W-1:0] reg_addr   = '0;
    logic [`FSC_DATA_W-1:0] reg_wdata  = '0;
    logic [`FSC_ADDR_W-1:0] reg_raddr  = '0;
    logic                   trig_pin   = 1'b0;
    logic [`FSC_ACC_W-1:0]  frac_start = 48'h0000_0100_0000;
    logic [`FSC_DATA_W-1:0] reg_rdata;
    logic [`FSC_ACC_W-1:0]  frac_value;
    logic [`FSC_ACC_W-1:0]  seed_value;
    logic                   seed_load;
    logic                   ramp_up;
    logic                   sweep_busy;
    int                     error_cnt  = 0;
    int                     check_count = 0;
    int                     b, n1, n5, n0;

    localparam logic [47:0] USZ = {30'h3, 18'h30001};
    localparam logic [47:0] DSZ = {30'h1, 18'h0020d};
    localparam logic [29:0] EN = 30'h800, SYM = 30'h400000, ONE = 30'h2000000, DIR = 30'h4000000;
    localparam logic [29:0] AUTO = 30'h100, DLY = 30'h80, SRC = 30'h2000, SWT = 30'h1000;
    localparam logic [4:0]  CTL = `FSC_OFS_SWEEP_CTRL;

    always #2 ref_clk = ~ref_clk;

    fsc_sweep dut_u (
        .REF_CLK(ref_clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RADDR(reg_raddr), .REG_RDATA(reg_rdata), .EXTERNAL_TRIGGER_PIN(trig_pin),
        .FRAC_START(frac_start), .FRAC_VALUE(frac_value), .SEED_LOAD(seed_load), .SEED_VALUE(seed_value),
        .RAMP_UP(ramp_up), .SWEEP_BUSY(sweep_busy)
    );

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [29:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [29:0] exp);
        @(posedge ref_clk);
        #1;
        reg_raddr = a;
        @(posedge ref_clk);
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step

    // busy must stay low; a stray start shows up here
    task automatic quiet();
        logic bad;
        bad = 1'b0;
        repeat (20) begin
            step(1);
            if (sweep_busy !== 1'b0) bad = 1'b1;
        end
        chk(bad, 0);
    endtask : quiet

    task automatic idle();
        int n;
        n = 0;
        while (sweep_busy !== 1'b0 && n < 2000) begin
            step(1);
            n++;
        end
    endtask : idle

    task automatic t_regs();
        rd(CTL, 30'h0);
        wr(`FSC_OFS_UP_SIZE_HI, USZ[47:18]);
        wr(`FSC_OFS_UP_SIZE_LO, {12'h0, USZ[17:0]});
        wr(`FSC_OFS_UP_CNT_LO, 30'h5);
        wr(`FSC_OFS_UP_DWELL_LO, 30'h3);
        wr(`FSC_OFS_DN_SIZE_HI, DSZ[47:18]);
        wr(`FSC_OFS_DN_SIZE_LO, {12'h0, DSZ[17:0]});
        wr(`FSC_OFS_DN_CNT_LO, 30'h7);
        wr(`FSC_OFS_DN_DWELL_LO, 30'h2);
        wr(`FSC_OFS_SEED_HI, 30'h5);
        wr(`FSC_OFS_SEED_LO, 30'habc);
        wr(`FSC_OFS_TRIG_DELAY, 30'h1fffff);
        rd(`FSC_OFS_UP_SIZE_HI, USZ[47:18]);
        rd(`FSC_OFS_UP_SIZE_LO, {12'h0, USZ[17:0]});
        rd(`FSC_OFS_TRIG_DELAY, 30'h1fffff);
        chk(seed_value, {30'h5, 18'habc});
        wr(CTL, SYM | SWT);
        rd(CTL, SYM);
        quiet();
    endtask : t_regs

    task automatic run(input logic [29:0] c, input logic [47:0] exp, input int nseed);
        int n;
        int s;
        logic up;
        n = 0;
        s = 0;
        up = 1'b0;
        wr(CTL, c);
        wr(CTL, c | SWT);
        while (n < 2000 && !(up && sweep_busy === 1'b0)) begin
            if (sweep_busy === 1'b1) up = 1'b1;
            if (seed_load === 1'b1) s++;
            step(1);
            n++;
        end
        chk(n < 2000, 1);
        chk(frac_value, exp);
        chk(s, nseed);
        chk(ramp_up, ((c & ONE) != 0) ? ((c & DIR) != 0) : ((c & DIR) == 0));
    endtask : run

    task automatic lat(input logic [29:0] c, input logic [29:0] d, output int n);
        wr(`FSC_OFS_TRIG_DELAY, d);
        wr(CTL, c);
        wr(CTL, c | SWT);
        n = 0;
        while (seed_load !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        idle();
    endtask : lat

    task automatic t_trig();
        wr(CTL, EN | SYM | ONE | DIR | SRC);
        wr(CTL, EN | SYM | ONE | DIR | SRC | SWT);
        quiet();
        // pin already configured as an enabled input by the host
        trig_pin = 1'b1;
        step(1);
        trig_pin = 1'b0;
        step(3);
        chk(sweep_busy, 1);
        idle();
        wr(CTL, EN | SYM | ONE | DIR);
        trig_pin = 1'b1;
        step(1);
        trig_pin = 1'b0;
        quiet();
    endtask : t_trig

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial begin
        step(20);
        rst_n = 1'b1;
        t_regs();
        run(EN | SYM | ONE | DIR | AUTO, frac_start + USZ * 5, 1);
        run(EN | SYM | ONE | AUTO, frac_start - USZ * 5, 1);
        run(EN | SYM | DIR | AUTO, frac_start, 2);
        run(EN | DIR, frac_start + USZ * 5 - DSZ * 7, 0);
        run(EN | AUTO, frac_start - DSZ * 7 + USZ * 5, 2);
        lat(EN | SYM | ONE | DIR | AUTO, 30'h5, b);
        lat(EN | SYM | ONE | DIR | AUTO | DLY, 30'h1, n1);
        chk(n1, b + 1);
        lat(EN | SYM | ONE | DIR | AUTO | DLY, 30'h5, n5);
        chk(n5, b + 5);
        lat(EN | SYM | ONE | DIR | AUTO | DLY, 30'h0, n0);
        chk(n0, b);
        t_trig();
        finish_test();
    end
endmodule : fsc_sweep_bench

//--- tb/fsc_sweep_sva.sv
// fsc_sweep_sva: port-level checks of the sweep control block.
// assumes: bound to fsc_sweep; keeps its own shadow of every register write.
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_sweep_sva
    import fsc_pkg::*;
(
    // clock and reset
    input wire logic                   REF_CLK,
    input wire logic                   RST_N,
    // register ports
    input wire logic                   REG_WR,
    input wire logic [`FSC_ADDR_W-1:0] REG_ADDR,
    input wire logic [`FSC_DATA_W-1:0] REG_WDATA,
    input wire logic [`FSC_ADDR_W-1:0] REG_RADDR,
    input wire logic [`FSC_DATA_W-1:0] REG_RDATA,
    // trigger and modulator side
    input wire logic                   EXTERNAL_TRIGGER_PIN,
    input wire logic [`FSC_ACC_W-1:0]  FRAC_START,
    input wire logic [`FSC_ACC_W-1:0]  FRAC_VALUE,
    input wire logic                   SEED_LOAD,
    input wire logic [`FSC_ACC_W-1:0]  SEED_VALUE,
    input wire logic                   RAMP_UP,
    input wire logic                   SWEEP_BUSY
);
    logic [`FSC_DATA_W-1:0] sh [32];
    logic [`FSC_DATA_W-1:0] ctl;
    logic [`FSC_ACC_W-1:0]  usz;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < 32; i++) sh[i] <= '0;
        end else if (REG_WR) begin
            sh[REG_ADDR] <= REG_WDATA;
        end
    end
    assign ctl = sh[`FSC_OFS_SWEEP_CTRL];
    assign usz = {sh[`FSC_OFS_UP_SIZE_HI], sh[`FSC_OFS_UP_SIZE_LO][`FSC_LO_W-1:0]};

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    // a step while ramping in symmetric mode; a reload of the start value is also legal
    sequence s_step;
        SWEEP_BUSY && $past(SWEEP_BUSY) && FRAC_VALUE != $past(FRAC_VALUE) && ctl[`FSC_BIT_SYM];
    endsequence
    property p_step_up;
        s_step ##0 (RAMP_UP && $past(RAMP_UP)) |-> FRAC_VALUE == $past(FRAC_VALUE) + usz || FRAC_VALUE == FRAC_START;
    endproperty
    property p_step_down;
        s_step ##0 (!RAMP_UP && !$past(RAMP_UP)) |-> FRAC_VALUE == $past(FRAC_VALUE) - usz || FRAC_VALUE == FRAC_START;
    endproperty
    property p_reset;
        $rose(RST_N) |-> FRAC_VALUE == '0 && !SWEEP_BUSY && !SEED_LOAD && !RAMP_UP;
    endproperty
    property p_disabled;
        !ctl[`FSC_BIT_SWEEP_EN] && !SWEEP_BUSY |=> !SWEEP_BUSY;
    endproperty
    property p_seed_auto;
        SEED_LOAD |-> ctl[`FSC_BIT_AUTOSEED] && SWEEP_BUSY;
    endproperty
    property p_seed_pulse;
        SEED_LOAD |=> !SEED_LOAD;
    endproperty
    property p_seed_val;
        (!REG_WR) [*2] |-> SEED_VALUE == {sh[`FSC_OFS_SEED_HI], sh[`FSC_OFS_SEED_LO][`FSC_LO_W-1:0]};
    endproperty
    property p_rd_size;
        REG_RADDR == `FSC_OFS_UP_SIZE_HI && !REG_WR |=> REG_RDATA == $past(sh[`FSC_OFS_UP_SIZE_HI]);
    endproperty
    property p_rd_ctl;
        REG_RADDR == `FSC_OFS_SWEEP_CTRL && !REG_WR |=> REG_RDATA == ($past(ctl) & ~30'h0001000);
    endproperty

    a_step_up: assert property (p_step_up) else $error("up step differs from up size");
    a_step_down: assert property (p_step_down) else $error("down step differs from up size");
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    a_disabled: assert property (p_disabled) else $error("sweep started while disabled");
    a_seed_auto: assert property (p_seed_auto) else $error("seed load without autoseed");
    a_seed_pulse: assert property (p_seed_pulse) else $error("seed load longer than one cycle");
    a_seed_val: assert property (p_seed_val) else $error("seed value not from seed words");
    a_rd_size: assert property (p_rd_size) else $error("up size high readback wrong");
    a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
endmodule : fsc_sweep_sva

bind fsc_sweep fsc_sweep_sva chk_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RADDR(REG_RADDR), .REG_RDATA(REG_RDATA), .EXTERNAL_TRIGGER_PIN(EXTERNAL_TRIGGER_PIN),
    .FRAC_START(FRAC_START), .FRAC_VALUE(FRAC_VALUE), .SEED_LOAD(SEED_LOAD), .SEED_VALUE(SEED_VALUE),
    .RAMP_UP(RAMP_UP), .SWEEP_BUSY(SWEEP_BUSY)
);
